/* core/pct_pkg.sv */
// Package for the PCI target transaction block: timing, decode and command constants.
// Assumes a single 125 MHz clock standing in for the PCI clock; PCI pins arrive synchronous.
// Overview of operation
// - On the edge after the address phase the target captures and decodes address and command.
// - After the address phase the shared lines carry only data and byte enables.
// - The target generates the sequential addresses of later burst data phases itself.
// - A target that decodes a hit claims the transaction by asserting its select line.
// - Only byte lanes with asserted byte enables move in a data phase; the target drives read data on all four lanes.
// - A data phase moves data on an edge with both ready lines asserted, otherwise a wait state repeats it.
// - After the final transfer the target releases both its ready and its select.
// - The bus is idle only when frame, both readies and select are all high.
package pct_pkg;
  localparam int ADDR_W = 32;
  localparam int CMD_W = 4;
  localparam int BE_W = 4;
  localparam int NUM_BAR = 6;
  // Each range spans eight byte addresses
  localparam int BAR_SPAN_BITS = 3;
  localparam logic [3:0] CMD_IO_READ = 4'h2;
  localparam logic [3:0] CMD_IO_WRITE = 4'h3;
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
  localparam logic [31:0] RESET_ADDR = 32'h0000_0000;
  localparam logic [3:0] RESET_CMD = 4'h0;
  // Wait states the back end may add before ready, counted in clocks
  localparam int WAIT_CNT_W = 4;
endpackage

/* core/pct_bar_match.sv */
// One base-address comparator for the target decode.
// Assumes the base value is held stable while transactions run.
`timescale 1ns/1ns
module pct_bar_match #(
  parameter int SPAN_BITS = 3
) (
  // Compare inputs
  input wire logic [31:0] addr,
  input wire logic [31:0] base,
  input wire logic enable,
  // Result
  output logic hit
);
  assign hit = enable && (addr[31:SPAN_BITS] == base[31:SPAN_BITS]);
endmodule

/* core/pct_target.sv */
// PCI target transaction sequencer: capture, decode, claim, wait states, burst addressing, release.
// Assumes the initiator keeps its own side of the protocol; the back end answers with a ready level.
`timescale 1ns/1ns
module pct_target
  import pct_pkg::*;
#(
  parameter int NUM_RANGES = pct_pkg::NUM_BAR
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // PCI initiator side
  input wire logic frameN,
  input wire logic irdyN,
  input wire logic [pct_pkg::ADDR_W-1:0] adIn,
  input wire logic [pct_pkg::CMD_W-1:0] cbeN,
  output logic [pct_pkg::ADDR_W-1:0] adOut,
  output logic adOe,
  output logic devselN,
  output logic devselOe,
  output logic trdyN,
  output logic trdyOe,
  // Base ranges
  input wire logic [NUM_RANGES*32-1:0] barBase,
  input wire logic [NUM_RANGES-1:0] barEnable,
  // Back end
  input wire logic beReady,
  input wire logic [31:0] beRdata,
  output logic [31:0] beAddr,
  output logic [3:0] beCmd,
  output logic [5:0] beRangeHit,
  output logic beWrite,
  output logic beXfer,
  output logic [31:0] beWdata,
  output logic [3:0] beByteEn,
  output logic busIdle
);
  import pct_pkg::*;

  typedef enum logic [1:0] {PCT_IDLE, PCT_DATA, PCT_BUSY} pct_state_e;

  ////////////////////////////////////////////////////////////////
  logic frameQ;
  logic [31:0] addrQ;
  logic [3:0] cmdQ;
  logic [NUM_RANGES-1:0] hitVec;
  logic isHit;
  logic cmdOk;
  logic addrPhase;
  logic xfer;
  logic lastXfer;
  pct_state_e state_q;

  // Address phase is frame falling while the bus was idle
  assign addrPhase = !frameN && frameQ && (state_q == PCT_IDLE);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_RANGES; gi++) begin : g_bar
      pct_bar_match #(.SPAN_BITS(BAR_SPAN_BITS)) u_match (
        .addr(adIn),
        .base(barBase[gi*32 +: 32]),
        .enable(barEnable[gi]),
        .hit(hitVec[gi])
      );
    end
  endgenerate

  assign cmdOk = (cbeN == CMD_IO_READ) || (cbeN == CMD_IO_WRITE) ||
                 (cbeN == CMD_MEM_READ) || (cbeN == CMD_MEM_WRITE);
  assign isHit = (|hitVec) && cmdOk;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      frameQ <= 1'b1;
    end else begin
      frameQ <= frameN;
    end
  end

  ////////////////////////////////////////////////////////////////
  // both ready lines low
  assign xfer = (state_q == PCT_DATA) && !irdyN && !trdyN;
  // last phase when frame is high
  assign lastXfer = xfer && frameN;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= PCT_IDLE;
    end else begin
      case (state_q)
        PCT_IDLE: begin
          // A miss still waits for the foreign transaction to end
          if (addrPhase) begin
            state_q <= isHit ? PCT_DATA : PCT_BUSY;
          end
        end
        PCT_DATA: begin
          if (lastXfer) begin
            state_q <= PCT_IDLE;
          end
        end
        default: begin
          if (frameN && irdyN) begin
            state_q <= PCT_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addrQ <= RESET_ADDR;
      cmdQ <= RESET_CMD;
      beRangeHit <= 6'h00;
    end else if (addrPhase) begin
      addrQ <= adIn;
      cmdQ <= cbeN;
      beRangeHit <= 6'(hitVec);
    end else if (xfer) begin
      addrQ <= addrQ + ADDR_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////
  // claim with select
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      devselN <= 1'b1;
    end else if (addrPhase && isHit) begin
      devselN <= 1'b0;
    end else if (lastXfer) begin
      devselN <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trdyN <= 1'b1;
    end else if (state_q == PCT_DATA && !lastXfer && !(xfer && !trdyN)) begin
      trdyN <= !beReady;
    end else begin
      trdyN <= 1'b1;
    end
  end

  assign devselOe = (state_q == PCT_DATA);
  assign trdyOe = (state_q == PCT_DATA);

  ////////////////////////////////////////////////////////////////
  // lines carry data and byte enables
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      beWdata <= 32'h0000_0000;
      beByteEn <= 4'h0;
      beXfer <= 1'b0;
      adOut <= 32'h0000_0000;
    end else begin
      beXfer <= xfer;
      if (xfer) begin
        beByteEn <= ~cbeN;
        beWdata <= adIn & {{8{~cbeN[3]}}, {8{~cbeN[2]}}, {8{~cbeN[1]}}, {8{~cbeN[0]}}};
      end
      adOut <= beRdata;
    end
  end

  assign adOe = (state_q == PCT_DATA) && !cmdQ[0];
  assign beAddr = addrQ;
  assign beCmd = cmdQ;
  assign beWrite = cmdQ[0];
  assign busIdle = frameN && irdyN && trdyN && devselN;

  ////////////////////////////////////////////////////////////////
  property p_claim;
    @(posedge ref_clk) disable iff (rst) addrPhase && isHit |=> !devselN;
  endproperty
  a_claim: assert property (p_claim) else $error("select not asserted after hit");

  property p_noclaim;
    @(posedge ref_clk) disable iff (rst) addrPhase && !isHit |=> devselN && trdyN;
  endproperty
  a_noclaim: assert property (p_noclaim) else $error("claimed a miss");

  property p_release;
    @(posedge ref_clk) disable iff (rst) lastXfer |=> devselN && trdyN;
  endproperty
  a_release: assert property (p_release) else $error("not released after last transfer");

  property p_latch;
    @(posedge ref_clk) disable iff (rst) addrPhase |=> addrQ == $past(adIn) && cmdQ == $past(cbeN);
  endproperty
  a_latch: assert property (p_latch) else $error("address or command not latched");

  property p_burst;
    @(posedge ref_clk) disable iff (rst) xfer |=> addrQ == $past(addrQ) + ADDR_STEP;
  endproperty
  a_burst: assert property (p_burst) else $error("burst address not stepped");

  property p_wait;
    @(posedge ref_clk) disable iff (rst) (state_q == PCT_DATA) && (irdyN || trdyN) |=> addrQ == $past(addrQ);
  endproperty
  a_wait: assert property (p_wait) else $error("address moved in wait state");

  property p_lanes;
    @(posedge ref_clk) disable iff (rst) xfer |=> beByteEn == ~$past(cbeN);
  endproperty
  a_lanes: assert property (p_lanes) else $error("byte enables not passed");

  property p_idle;
    @(posedge ref_clk) disable iff (rst) busIdle |-> !devselOe && !trdyOe && !adOe;
  endproperty
  a_idle: assert property (p_idle) else $error("idle flagged with bus active");

  property p_ready_only_claimed;
    @(posedge ref_clk) disable iff (rst) !trdyN |-> !devselN;
  endproperty
  a_ready_only_claimed: assert property (p_ready_only_claimed) else $error("ready without select");
endmodule

/* tb/pct_initiator.sv */
// Behavioural PCI initiator that drives the target's bus inputs.
// Assumes one shared clock; it changes its lines 1 ns after a rising edge.
`timescale 1ns/1ns
module pct_initiator (
  // Clock
  input wire logic ref_clk,
  // Bus lines
  output logic frameN,
  output logic irdyN,
  output logic [31:0] adIn,
  output logic [3:0] cbeN,
  input wire logic trdyN
);
  initial begin
    frameN = 1'b1;
    irdyN = 1'b1;
    adIn = 32'h0000_0000;
    cbeN = 4'hf;
  end
  ////////////////////////////////////////////////////////////////
  // address phase, then data
  task automatic burst(input logic [31:0] a, input logic [3:0] c, input logic [3:0] be, input int n, output int k);
    int t;
    @(posedge ref_clk);
    #1;
    frameN = 1'b0;
    adIn = a;
    cbeN = c;
    @(posedge ref_clk);
    #1;
    irdyN = 1'b0;
    frameN = (n == 1);
    adIn = 32'h1000_0000;
    cbeN = ~be;
    k = 0;
    for (t = 0; t < 16 && k < n; t++) begin
      @(posedge ref_clk);
      if (trdyN === 1'b0) begin
        k++;
        #1;
        if (k == n) begin
          irdyN = 1'b1;
          adIn = ~adIn;
          cbeN = 4'hf;
        end else begin
          adIn = adIn + 32'h0000_0001;
          frameN = (k >= n - 1);
        end
      end
    end
    // Nobody claimed: give the bus up, lines no longer hold data
    if (k < n) begin
      #1;
      frameN = 1'b1;
      irdyN = 1'b1;
      adIn = ~adIn;
    end
  endtask
endmodule

/* tb/pct_target_test.sv */
// Self-checking bench for the PCI target sequencer.
// Assumes the initiator model and a simple back end made here.
`timescale 1ns/1ns
module pct_target_test;
  import pct_pkg::*;
  logic ref_clk, rst, frameN, irdyN, beReady, slow, claimed;
  logic adOe, devselN, devselOe, trdyN, trdyOe, beWrite, beXfer, busIdle;
  logic [31:0] adIn, adOut, beRdata, beAddr, beWdata;
  logic [3:0] cbeN, beCmd, beByteEn;
  logic [3:0] cmdNow, beNow;
  logic [31:0] rdPrev;
  logic [5:0] beRangeHit, barEnable;
  logic [191:0] barBase;
  logic [31:0] qa[$], qd[$];
  int nFail, nTests, i;
  pct_target u_pct_target(.ref_clk(ref_clk), .rst(rst), .frameN(frameN), .irdyN(irdyN), .adIn(adIn), .cbeN(cbeN),
    .adOut(adOut), .adOe(adOe), .devselN(devselN), .devselOe(devselOe), .trdyN(trdyN), .trdyOe(trdyOe),
    .barBase(barBase), .barEnable(barEnable), .beReady(beReady), .beRdata(beRdata), .beAddr(beAddr),
    .beCmd(beCmd), .beRangeHit(beRangeHit), .beWrite(beWrite), .beXfer(beXfer), .beWdata(beWdata),
    .beByteEn(beByteEn), .busIdle(busIdle));
  pct_initiator u_pct_initiator(.ref_clk(ref_clk), .frameN(frameN), .irdyN(irdyN), .adIn(adIn), .cbeN(cbeN),
    .trdyN(trdyN));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (trdyN === 1'b0 && irdyN === 1'b0) begin
      qa.push_back(beAddr);
      check({30'h0, adOe, trdyOe}, {30'h0, ~cmdNow[0], 1'b1});
      if (!cmdNow[0]) check(adOut, rdPrev);
    end
    if (devselN === 1'b0) claimed = 1'b1;
    if (beXfer === 1'b1) begin
      qd.push_back(beWdata);
      check({28'h0, beByteEn}, {28'h0, beNow});
    end
    // Read data leaves one clock after the back end offers it
    rdPrev = beRdata;
    #1;
    beReady = slow ? ~beReady : 1'b1;
    beRdata = beRdata + 32'h0000_0001;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tallyAndFinish;
    $display("comparisons %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [31:0] base(input int r);
    return 32'h0000_1000 + 32'(r) * 32'h0000_0100;
  endfunction
  // One transaction; r is the range expected to claim it
  task automatic xact(input logic [31:0] a, input logic [3:0] c, input logic [3:0] be, input int n, input logic hit,
    input int r);
    int k, j;
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    qa.delete();
    qd.delete();
    claimed = 1'b0;
    cmdNow = c;
    beNow = be;
    u_pct_initiator.burst(a, c, be, n, k);
    repeat (2) @(posedge ref_clk);
    #1;
    check(32'(k), 32'(hit ? n : 0));
    check({31'h0, claimed}, {31'h0, hit});
    check({29'h0, devselN, trdyN, busIdle}, 32'h0000_0007);
    check(32'(qa.size()), 32'(hit ? n : 0));
    check(32'(qd.size()), 32'(hit ? n : 0));
    for (j = 0; j < qa.size(); j++) begin
      check(qa[j], a + 32'(4 * j));
      if (c[0] && j < qd.size()) check(qd[j], (32'h1000_0000 + 32'(j)) & m);
    end
    if (hit) check({23'h0, beCmd, beWrite, beRangeHit[3:0]}, {23'h0, c, c[0], 4'(1 << r)});
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    nFail++;
    tallyAndFinish;
  end
  initial begin
    rst = 1'b1;
    slow = 1'b0;
    beReady = 1'b0;
    beRdata = 32'hd000_0000;
    barEnable = 6'h1f;
    for (i = 0; i < 6; i++) barBase[i*32+:32] = base(i);
    repeat (3) @(posedge ref_clk);
    #1;
    check({27'h0, devselN, trdyN, adOe, devselOe, trdyOe}, 32'h0000_0018);
    rst = 1'b0;
    xact(base(0), CMD_IO_READ, 4'hf, 1, 1'b1, 0);
    xact(base(1), CMD_IO_WRITE, 4'h5, 2, 1'b1, 1);
    xact(base(2), CMD_MEM_READ, 4'hf, 2, 1'b1, 2);
    xact(base(3) + 32'h4, CMD_MEM_WRITE, 4'ha, 1, 1'b1, 3);
    slow = 1'b1;
    xact(base(1), CMD_MEM_WRITE, 4'h3, 2, 1'b1, 1);
    xact(base(0), CMD_IO_READ, 4'hf, 2, 1'b1, 0);
    xact(base(5), CMD_IO_WRITE, 4'hf, 1, 1'b0, 5);
    xact(32'h0000_0f00, CMD_MEM_READ, 4'hf, 1, 1'b0, 0);
    xact(base(4), 4'ha, 4'hf, 1, 1'b0, 4);
    tallyAndFinish;
  end
endmodule
